//--- led_array_model.sv
// row sink and column source model: times lit spans, keeps each row's columns
// assumes enables change only just after i_clk edges
`timescale 1ns/100ps
module led_array_model
    import led_scan_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic [ROWS-1:0] i_row_en,
    input  wire logic [COLS-1:0] i_col_en
);
    int              run = 0, per = 0, frm = 0, lit_len = 0, per_len = 0, frm_len = 0, n_rows = 0;
    logic [ROWS-1:0] prev_r = '0;
    logic [COLS-1:0] cols [ROWS];
    always @(posedge i_clk) begin
        prev_r <= i_row_en;
        run <= (i_row_en != '0) ? run + 1 : 0;
        per <= per + 1;
        frm <= frm + 1;
        if (i_row_en != '0)
            cols[$clog2(i_row_en)] <= i_col_en;
        if (i_row_en == '0 && prev_r != '0)
            lit_len <= run;
        if (i_row_en != '0 && prev_r == '0) begin
            per_len <= per;
            per <= 1;
            n_rows <= n_rows + 1;
        end
        if (i_row_en[0] && !prev_r[0]) begin
            frm_len <= frm;
            frm <= 1;
        end
    end
endmodule

//--- led_matrix_refresh_scanner.sv
// refresh scanner: apb registers, display clock select, row/column drive
// assumes an apb master on i_ref_clk; external oscillator is asynchronous
//
// Contract
// RL1 - full scan takes exactly 512 display cycles
// RL2 - eight rows enabled in turn, 64 cycles
// RL3 - last four slot cycles blank, max 60 lit
// RL4 - 160 dots as 20 columns by 8 rows
// RL5 - only one row's columns active at once
// RL6 - display clock internal or external keeps step
// RL7 - on-time per slot follows duty setting
// RL8 - bits 5:4 peak, bits 3:0 duty
// RL9 - peak bits zero give 73 percent current
// RL10 - duty 1101 gives 60 percent on-time
// RL11 - external oscillator at least 51.2 kHz
// RL12 - external oscillator below 1 or 8 MHz
// RL13 - prescaler bit divides external oscillator by 8
// RL14 - row index 0..7 advances each slot, wraps
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module led_matrix_refresh_scanner
    import led_scan_pkg::*;
(
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [7:0]        i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic              i_ext_osc,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic      [ROWS-1:0]   o_row_en,
    output logic      [COLS-1:0]   o_col_en,
    output logic      [1:0]        o_peak_sel
);
    // duty code to lit cycles out of 64; 4'hd is 60 % of the 60-cycle full on-time
    function automatic logic [5:0] duty_cycles(input logic [3:0] code);
        logic [5:0] c;
        c = 6'h00;
        unique case (code)
            4'hd:    c = 6'(DUTY60_CYC);                       // [RL10]
            4'hf:    c = 6'(MAX_ON_CYC);
            default: c = 6'((int'(code) * MAX_ON_CYC) / 15);
        endcase
        return c;
    endfunction

    function automatic logic [2:0] word_idx(input logic [7:0] a);
        return a[4:2];
    endfunction

    typedef enum logic [2:0] {
        SEL_DOT    = 3'b000,
        SEL_BRIGHT = 3'b001,
        SEL_CLKCFG = 3'b010,
        SEL_STATUS = 3'b011,
        SEL_NONE   = 3'b100
    } reg_sel_t;

    // misaligned and unmapped words both fall to the refused code
    function automatic reg_sel_t decode(input logic [7:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (a[1:0] == 2'h0) begin
            if (a < ADDR_BRIGHT && word_idx(a) < 3'(DOT_WORDS)) begin
                s = SEL_DOT;
            end else if (a == ADDR_BRIGHT) begin
                s = SEL_BRIGHT;
            end else if (a == ADDR_CLKCFG) begin
                s = SEL_CLKCFG;
            end else if (a == ADDR_STATUS) begin
                s = SEL_STATUS;
            end
        end
        return s;
    endfunction

    logic [DOTS-1:0] dots_r, dots_nxt;
    bright_t         bright_r, bright_nxt;
    logic [1:0]      clkcfg_r, clkcfg_nxt;
    logic [31:0]     prdata_r, prdata_nxt;
    logic            pready_r, pready_nxt;
    logic            pslverr_r, pslverr_nxt;
    logic [5:0]      slot_cnt_r, slot_cnt_nxt;
    logic [2:0]      row_r, row_nxt;
    reg_sel_t        sel_w;

    // apb: one wait state, answer registered; a write lands only at the
    // edge where the master samples pready, a refused one never lands
    logic acc;
    logic fin;
    assign acc = i_psel & i_penable & ~pready_r;
    assign fin = i_psel & i_penable & i_pwrite & pready_r & ~pslverr_r;

    always_comb begin
        sel_w       = decode(i_paddr);
        dots_nxt    = dots_r;
        bright_nxt  = bright_r;
        clkcfg_nxt  = clkcfg_r;
        prdata_nxt  = prdata_r;
        pready_nxt  = acc;
        pslverr_nxt = 1'b0;
        if (acc) begin
            prdata_nxt = 32'h0000_0000;
            unique case (sel_w)
                SEL_DOT: begin
                    prdata_nxt = dots_r[32*word_idx(i_paddr) +: 32];
                end
                SEL_BRIGHT: begin
                    prdata_nxt = {26'h0, bright_r};
                end
                SEL_CLKCFG: begin
                    prdata_nxt = {30'h0, clkcfg_r};
                end
                SEL_STATUS: begin
                    prdata_nxt  = {23'h0, slot_cnt_r, row_r};
                    pslverr_nxt = i_pwrite;                            // status is read-only
                end
                default: begin
                    pslverr_nxt = 1'b1;
                end
            endcase
        end
        if (fin) begin
            unique case (sel_w)
                SEL_DOT: begin
                    dots_nxt[32*word_idx(i_paddr) +: 32] = i_pwdata;   // [RL4]
                end
                SEL_BRIGHT: begin
                    bright_nxt = bright_t'(i_pwdata[5:0]);             // [RL8]
                end
                SEL_CLKCFG: begin
                    clkcfg_nxt = i_pwdata[1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            dots_r    <= '0;
            bright_r  <= bright_t'(BRIGHT_RST);
            clkcfg_r  <= CLKCFG_RST;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            dots_r    <= dots_nxt;
            bright_r  <= bright_nxt;
            clkcfg_r  <= clkcfg_nxt;
            prdata_r  <= prdata_nxt;
            pready_r  <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // display clock tick: external pin synchronised, edge counted
    logic [2:0] ext_sync_r, ext_sync_nxt;
    logic [2:0] pre_cnt_r, pre_cnt_nxt;
    logic [6:0] int_cnt_r, int_cnt_nxt;
    logic       tick;
    logic       ext_rise;

    assign ext_rise = ext_sync_r[1] & ~ext_sync_r[2];

    always_comb begin
        ext_sync_nxt = {ext_sync_r[1:0], i_ext_osc};
        pre_cnt_nxt  = pre_cnt_r;
        int_cnt_nxt  = (int_cnt_r == 7'(INT_OSC_DIV - 1)) ? 7'h00 : int_cnt_r + 7'h01;
        tick         = 1'b0;
        if (clkcfg_r[CFG_EXT_BIT]) begin                              // [RL6]
            if (ext_rise) begin
                if (clkcfg_r[CFG_PRE_BIT]) begin                      // [RL13]
                    pre_cnt_nxt = pre_cnt_r + 3'h1;
                    tick        = (pre_cnt_r == 3'(PRESCALE_DIV - 1));
                end else begin
                    tick = 1'b1;
                end
            end
        end else begin
            tick = (int_cnt_r == 7'(INT_OSC_DIV - 1));
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            ext_sync_r <= 3'h0;
            pre_cnt_r  <= 3'h0;
            int_cnt_r  <= 7'h00;
        end else begin
            ext_sync_r <= ext_sync_nxt;
            pre_cnt_r  <= pre_cnt_nxt;
            int_cnt_r  <= int_cnt_nxt;
        end
    end

    // scan counters: 8 slots of 64 ticks make a 512-tick frame
    drive_t          drv_r, drv_nxt;
    logic            lit;

    always_comb begin
        slot_cnt_nxt = slot_cnt_r;
        row_nxt      = row_r;
        if (tick) begin
            slot_cnt_nxt = slot_cnt_r + 6'h01;                        // [RL2]
            if (slot_cnt_r == 6'(SLOT_CYC - 1)) begin
                row_nxt = (row_r == 3'(ROWS - 1)) ? 3'h0 : row_r + 3'h1;   // [RL14] [RL1]
            end
        end
        // lit from slot start until duty count, never into the blank tail
        lit = (slot_cnt_r < duty_cycles(bright_r.duty))                // [RL7]
            && (slot_cnt_r < 6'(MAX_ON_CYC));                          // [RL3]
        drv_nxt.row_en = '0;
        drv_nxt.col_en = '0;
        drv_nxt.peak   = bright_r.peak;                                // [RL9]
        if (lit) begin
            drv_nxt.row_en[row_r] = 1'b1;                              // [RL5]
            for (int c = 0; c < COLS; c++) begin
                drv_nxt.col_en[c] = dots_r[c*ROWS + int'(row_r)];      // [RL4]
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            slot_cnt_r <= 6'h00;
            row_r      <= 3'h0;
            drv_r      <= '0;
        end else begin
            slot_cnt_r <= slot_cnt_nxt;
            row_r      <= row_nxt;
            drv_r      <= drv_nxt;
        end
    end

    assign o_prdata   = prdata_r;
    assign o_pready   = pready_r;
    assign o_pslverr  = pslverr_r;
    assign o_row_en   = drv_r.row_en;
    assign o_col_en   = drv_r.col_en;
    assign o_peak_sel = drv_r.peak;
endmodule

//--- led_scan_assertions.sv
// port checker for the led matrix refresh scanner
// assumes binding onto the scanner top, one clock domain
`timescale 1ns/100ps
module led_scan_assertions
    import led_scan_pkg::*;
(
    input  wire logic            i_ref_clk,
    input  wire logic            i_rst_n,
    input  wire logic            i_psel,
    input  wire logic            i_penable,
    input  wire logic            i_pwrite,
    input  wire logic [31:0]     o_prdata,
    input  wire logic            o_pready,
    input  wire logic            o_pslverr,
    input  wire logic [ROWS-1:0] o_row_en,
    input  wire logic [COLS-1:0] o_col_en,
    input  wire logic [1:0]      o_peak_sel
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // last row that was lit, so skipped or reversed rows show up
    logic [ROWS-1:0] last_r;
    logic [ROWS-1:0] last_nxt;
    always_comb last_nxt = (o_row_en != '0) ? o_row_en : last_r;
    always_ff @(posedge i_ref_clk) last_r <= !i_rst_n ? '0 : last_nxt;

    ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("ready held");
    access_ready_a: assert property ($rose(i_psel && i_penable) |=> o_pready) else $error("ready late");
    err_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
    rdata_hold_a: assert property ($changed(o_prdata) |-> o_pready) else $error("read data moved");
    row_onehot_a: assert property ($onehot0(o_row_en)) else $error("two rows lit");
    blank_gap_a: assert property ((o_row_en != '0 && $past(o_row_en) != '0)
        |-> o_row_en == $past(o_row_en)) else $error("row switch without blank");
    row_order_a: assert property ((o_row_en != '0 && last_r != '0 && o_row_en != last_r)
        |-> o_row_en == {last_r[ROWS-2:0], last_r[ROWS-1]}) else $error("row order");
    peak_write_a: assert property ($changed(o_peak_sel) |-> $past(i_psel && i_penable && i_pwrite)
        || $past(i_psel && i_penable && i_pwrite, 2)) else $error("peak moved");
    cols_blank_a: assert property (o_row_en == '0 |-> o_col_en == '0) else $error("columns on while blank");
    cover property (o_pslverr);
    cover property (o_col_en != '0);
    cover property ($rose(o_row_en[ROWS-1]));
    cover property (o_peak_sel == 2'h3);
endmodule

bind led_matrix_refresh_scanner led_scan_assertions u_chk (.*);

//--- led_scan_pkg.sv
// package for the led matrix refresh scanner: register map, fields, timing
// assumes a 32-bit apb master and a 100 MHz i_ref_clk
package led_scan_pkg;
    localparam int unsigned      ROWS          = 8;
    localparam int unsigned      COLS          = 20;
    localparam int unsigned      DOTS          = 160;
    localparam int unsigned      FRAME_CYC     = 512;
    localparam int unsigned      SLOT_CYC      = 64;
    localparam int unsigned      BLANK_CYC     = 4;
    localparam int unsigned      MAX_ON_CYC    = SLOT_CYC - BLANK_CYC;
    // duty code 4'hd: 60 % of the full on-time
    localparam int unsigned      DUTY60_CYC    = (MAX_ON_CYC * 60) / 100;
    localparam int unsigned      PRESCALE_DIV  = 8;
    // register byte offsets
    localparam logic [7:0]       ADDR_DOT0     = 8'h00;  // dots 31..0, words up to 0x10
    localparam int unsigned      DOT_WORDS     = 5;
    localparam logic [7:0]       ADDR_BRIGHT   = 8'h20;
    localparam logic [7:0]       ADDR_CLKCFG   = 8'h24;
    localparam logic [7:0]       ADDR_STATUS   = 8'h28;
    // brightness word fields
    localparam int unsigned      PEAK_LSB      = 4;
    localparam int unsigned      DUTY_LSB      = 0;
    localparam logic [5:0]       BRIGHT_RST    = 6'h0d;  // 73 % peak, 60 % duty
    // clock config fields
    localparam int unsigned      CFG_EXT_BIT   = 0;
    localparam int unsigned      CFG_PRE_BIT   = 1;
    localparam logic [1:0]       CLKCFG_RST    = 2'h0;
    // internal display oscillator divider from 100 MHz
    localparam int unsigned      INT_OSC_DIV   = 100;

    typedef struct packed {
        logic [1:0] peak;
        logic [3:0] duty;
    } bright_t;

    typedef struct packed {
        logic [ROWS-1:0] row_en;
        logic [COLS-1:0] col_en;
        logic [1:0]      peak;
    } drive_t;
endpackage

//--- tb_top.sv
// apb-driven bench for the refresh scanner
// assumes the array model and checker are compiled first
`timescale 1ns/100ps
module tb_top;
    import led_scan_pkg::*;
    logic            clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0, osc = 0, rdy, err;
    logic [7:0]      adr = '0;
    logic [31:0]     wd = '0, rd, prd;
    logic [ROWS-1:0] row;
    logic [COLS-1:0] col, ec;
    logic [1:0]      pk;
    logic [DOTS-1:0] dots;
    int              error_cnt = 0, n_tests = 0, ocnt = 0, oper = 120;
    always #5 clk = ~clk;
    // external oscillator kept inside its recommended band
    always @(posedge clk) begin
        ocnt <= (ocnt >= oper - 1) ? 0 : ocnt + 1;
        osc <= ocnt < oper / 2;
    end
    led_matrix_refresh_scanner dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(sel), .i_penable(en),
        .i_pwrite(wr), .i_paddr(adr), .i_pwdata(wd), .i_ext_osc(osc), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(err), .o_row_en(row), .o_col_en(col), .o_peak_sel(pk));
    led_array_model m (.i_clk(clk), .i_row_en(row), .i_col_en(col));
    task chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask
    task xfer(logic w, logic [7:0] a, logic [31:0] d, logic e);
        @(posedge clk);
        sel <= 1;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        en <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        chk("pslverr", 32'(e), 32'(err));
        sel <= 0;
        en <= 0;
    endtask
    task rows(int n);
        int t;
        t = m.n_rows;
        wait (m.n_rows >= t + n);
        @(negedge clk);
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1;
        xfer(0, ADDR_BRIGHT, 0, 0);
        chk("bright", 32'h0d, rd);
        chk("peak", 0, 32'(pk));
        for (int k = 0; k < DOT_WORDS; k++) begin
            dots[k*32 +: 32] = 32'h9e3779b9 * (k + 1);
            xfer(1, ADDR_DOT0 + 8'(4 * k), dots[k*32 +: 32], 0);
        end
        xfer(0, ADDR_DOT0 + 8'h08, 0, 0);
        chk("dot word", dots[64 +: 32], rd);
        xfer(0, 8'h30, 0, 1);
        xfer(0, 8'h21, 0, 1);
        xfer(1, ADDR_STATUS, 0, 1);
        // prescale bit alone must leave the internal scan rate as it is
        xfer(1, ADDR_CLKCFG, 32'h2, 0);
        xfer(0, ADDR_CLKCFG, 0, 0);
        chk("clkcfg", 32'h2, rd);
        xfer(1, ADDR_BRIGHT, 32'h3d, 0);
        repeat (3) @(posedge clk);
        chk("peak", 3, 32'(pk));
        $display("register test done");
        rows(9);
        chk("frame", FRAME_CYC * 100, m.frm_len);
        chk("slot", SLOT_CYC * 100, m.per_len);
        chk("lit", DUTY60_CYC * 100, m.lit_len);
        for (int r = 0; r < ROWS; r++) begin
            for (int c = 0; c < COLS; c++) ec[c] = dots[c * 8 + r];
            chk("cols", 32'(ec), 32'(m.cols[r]));
        end
        $display("internal scan test done");
        xfer(1, ADDR_BRIGHT, 32'h0f, 0);
        xfer(1, ADDR_CLKCFG, 32'h1, 0);
        rows(2);
        chk("lit ext", MAX_ON_CYC * 120, m.lit_len);
        chk("slot ext", SLOT_CYC * 120, m.per_len);
        $display("external clock test done");
        oper <= 13;
        xfer(1, ADDR_BRIGHT, 32'h01, 0);
        xfer(1, ADDR_CLKCFG, 32'h3, 0);
        rows(2);
        chk("lit pre", 4 * 8 * 13, m.lit_len);
        chk("slot pre", SLOT_CYC * 8 * 13, m.per_len);
        $display("prescaler test done");
        final_report;
    end
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        final_report;
    end
endmodule
